// file: rtl/playback_switch_params.svh
// register offsets, reset values and field positions of the playback switch
`ifndef PLAYBACK_SWITCH_PARAMS_SVH
`define PLAYBACK_SWITCH_PARAMS_SVH
`define SPC_CTRL_ADDR       16'hD06E
`define SPC_CTRL_INDEX      16'hD06E
`define SPC_PORT_CFG_INDEX  16'hD06F
`define SPC_STATUS_INDEX    16'hD070
`define SPC_CTRL_RESET      8'h00
`define SPC_PORT_CFG_RESET  8'h00
`define SPC_VN_BIT          7
`define SPC_POL_BIT         6
`define SPC_CRH_BIT         5
`define SPC_HAH_BIT         4
`define SPC_SIG_HI          3
`define SPC_SIG_LO          0
`endif

// file: rtl/playback_switch_pkg.sv
// types shared by the playback switch files
package playback_switch_pkg;
    typedef logic [3:0] source_sel_t;
    typedef logic [7:0] ctrl_byte_t;
    typedef logic [31:0] word_t;
endpackage

// file: rtl/source_select.sv
// output source decoder for the chroma and head-amplifier select outputs
`timescale 1ns/1ps
module source_select (
    // selection field
    input  wire playback_switch_pkg::source_sel_t sel,
    // candidate sources
    input  wire logic                             head_sw,
    input  wire logic                             compare,
    input  wire logic                             rtp_bit,
    // decoded outputs
    output logic                                  chroma_raw,
    output logic                                  headamp_raw
);
    import playback_switch_pkg::*;

    // table decode of the signal control field
    always_comb begin
        chroma_raw  = 1'b0;
        headamp_raw = 1'b0;
        case (sel)
            4'h0: begin chroma_raw = 1'b0; headamp_raw = 1'b0; end
            4'h1: begin chroma_raw = head_sw; headamp_raw = 1'b0; end
            4'h2: begin chroma_raw = head_sw; headamp_raw = 1'b1; end
            4'h3: begin chroma_raw = 1'b0; headamp_raw = head_sw; end
            4'h4: begin chroma_raw = 1'b1; headamp_raw = head_sw; end
            4'h5: begin chroma_raw = head_sw ^ compare; headamp_raw = compare; end
            4'h6: begin chroma_raw = ~(head_sw ^ compare); headamp_raw = compare; end
            4'h7: begin chroma_raw = head_sw ^ rtp_bit; headamp_raw = rtp_bit; end
            default: begin chroma_raw = ~(head_sw ^ rtp_bit); headamp_raw = rtp_bit; end
        endcase
    end
endmodule // source_select

// file: rtl/four_head_playback_switch.sv
// four-head special playback switch: apb control byte, source select, line retiming
// Function
// - both outputs may be retimed to line sync
// - pins may serve as general ports
// - write-only control byte, cleared on reset/standby/stop
// - top bit picks video or narrow waveform
// - polarity bit inverts comparison input
// - chroma retimed when its sync bit zero
// - head-amp retimed when its sync bit zero
// - four-bit field selects output sources
`timescale 1ns/1ps
`include "playback_switch_params.svh"
module four_head_playback_switch (
    // clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         rst_b,
    // low-power entry
    input  wire logic                         standby,
    input  wire logic                         module_stop,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [15:0]                  paddr,
    input  wire playback_switch_pkg::word_t   pwdata,
    output logic                              pready,
    output playback_switch_pkg::word_t        prdata,
    output logic                              pslverr,
    // waveforms from the timing generator
    input  wire logic                         video_ff_signal,
    input  wire logic                         narrow_ff_signal,
    input  wire logic                         line_sync_ref,
    input  wire logic                         realtime_port_bit0,
    // comparison pin
    input  wire logic                         compare_in,
    // output pins; chroma and headamp carry port data when unused, compare_port_in always mirrors the comparison pin
    output logic                              chroma_ctrl_out,
    output logic                              headamp_select_out,
    output logic                              compare_port_in
);
    import playback_switch_pkg::*;

    logic       rst_s1_ff, rst_s2_ff;
    logic       cmp_s1_ff, cmp_s2_ff;
    logic       osc_s1_ff, osc_s2_ff, osc_prev_ff;
    logic       vid_s1_ff, vid_s2_ff;
    logic       nar_s1_ff, nar_s2_ff;
    logic       rtp_s1_ff, rtp_s2_ff;
    ctrl_byte_t ctrl_ff;
    ctrl_byte_t port_cfg_ff;
    logic       chroma_ff, headamp_ff, cmp_port_ff;
    logic       pready_ff, pslverr_ff;
    word_t      prdata_ff;

    // reset released through two flip-flops
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    wire rst_n = rst_s2_ff;

    // two-stage synchronisers on the comparison, line sync, waveform and port-bit inputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_s1_ff <= 1'b0;
            cmp_s2_ff <= 1'b0;
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            vid_s1_ff <= 1'b0;
            vid_s2_ff <= 1'b0;
            nar_s1_ff <= 1'b0;
            nar_s2_ff <= 1'b0;
            rtp_s1_ff <= 1'b0;
            rtp_s2_ff <= 1'b0;
            osc_prev_ff <= 1'b0;
        end else begin
            cmp_s1_ff <= compare_in;
            cmp_s2_ff <= cmp_s1_ff;
            osc_s1_ff <= line_sync_ref;
            osc_s2_ff <= osc_s1_ff;
            vid_s1_ff <= video_ff_signal;
            vid_s2_ff <= vid_s1_ff;
            nar_s1_ff <= narrow_ff_signal;
            nar_s2_ff <= nar_s1_ff;
            rtp_s1_ff <= realtime_port_bit0;
            rtp_s2_ff <= rtp_s1_ff;
            osc_prev_ff <= osc_s2_ff;
        end
    end

    // apb decode
    wire        apb_access = psel && penable;
    wire        apb_wr     = apb_access && pwrite;
    wire [13:0] word_addr  = paddr[15:2];
    wire        hit_ctrl   = word_addr == 14'(`SPC_CTRL_INDEX);
    wire        hit_port   = word_addr == 14'(`SPC_PORT_CFG_INDEX);
    wire        hit_stat   = word_addr == 14'(`SPC_STATUS_INDEX);
    wire        hit_any    = hit_ctrl || hit_port || hit_stat;
    wire        low_power  = standby || module_stop;

    // control fields
    wire         preamp_result_polarity = ctrl_ff[`SPC_POL_BIT];
    wire         chroma_sync_ctrl       = ctrl_ff[`SPC_CRH_BIT];
    wire         headamp_sync_ctrl      = ctrl_ff[`SPC_HAH_BIT];
    source_sel_t output_source_sel;
    assign output_source_sel = ctrl_ff[`SPC_SIG_HI:`SPC_SIG_LO];

    // waveform and comparison conditioning
    wire head_switch_signal = ctrl_ff[`SPC_VN_BIT] ? nar_s2_ff : vid_s2_ff;
    wire compare_eff        = cmp_s2_ff ^ preamp_result_polarity;
    wire sync_edge          = osc_s2_ff && !osc_prev_ff;

    logic chroma_raw, headamp_raw;

    source_select u_source_select (
        .sel         (output_source_sel),
        .head_sw     (head_switch_signal),
        .compare     (compare_eff),
        .rtp_bit     (rtp_s2_ff),
        .chroma_raw  (chroma_raw),
        .headamp_raw (headamp_raw)
    );

    // port mode when the switch function is disabled: bit0 enables switch,
    // bits 1/2 carry port data for the two outputs
    wire switch_en    = port_cfg_ff[0];
    wire chroma_upd   = chroma_sync_ctrl || sync_edge;
    wire headamp_upd  = headamp_sync_ctrl || sync_edge;
    wire nxt_chroma   = !switch_en ? port_cfg_ff[1] :
                        (chroma_upd ? chroma_raw : chroma_ff);
    wire nxt_headamp  = !switch_en ? port_cfg_ff[2] :
                        (headamp_upd ? headamp_raw : headamp_ff);
    wire [31:0] nxt_rdata = hit_stat ? {29'h0, cmp_port_ff, headamp_ff, chroma_ff} :
                            hit_port ? {24'h0, port_cfg_ff} : 32'h0;

    // control registers; ctrl is cleared on standby or module stop
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff     <= `SPC_CTRL_RESET;
            port_cfg_ff <= `SPC_PORT_CFG_RESET;
        end else if (low_power) begin
            ctrl_ff     <= `SPC_CTRL_RESET;
        end else if (apb_wr && pready_ff) begin // write lands at the edge that samples ready
            if (hit_ctrl) begin
                ctrl_ff <= pwdata[7:0];
            end
            if (hit_port) begin
                port_cfg_ff <= pwdata[7:0];
            end
        end
    end

    // output flip-flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chroma_ff   <= 1'b0;
            headamp_ff  <= 1'b0;
            cmp_port_ff <= 1'b0;
        end else begin
            chroma_ff   <= nxt_chroma;
            headamp_ff  <= nxt_headamp;
            cmp_port_ff <= cmp_s2_ff;
        end
    end

    // apb answer: one wait state, ready pulse in the second access cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else begin
            pready_ff  <= apb_access && !pready_ff;
            pslverr_ff <= apb_access && !pready_ff && !hit_any;
            prdata_ff  <= (apb_access && !pready_ff && !pwrite) ? nxt_rdata : 32'h0;
        end
    end

    assign pready             = pready_ff;
    assign pslverr            = pslverr_ff;
    assign prdata             = prdata_ff;
    assign chroma_ctrl_out    = chroma_ff;
    assign headamp_select_out = headamp_ff;
    assign compare_port_in    = cmp_port_ff;
endmodule // four_head_playback_switch

// file: tb/playback_switch_props.sv
// checker for the playback switch ports
`timescale 1ns/1ps
`include "playback_switch_params.svh"
module playback_switch_props (
    // all watched ports
    input wire logic ref_clk, rst_b, standby, module_stop, psel, penable, pwrite,
    input wire logic [15:0] paddr,
    input wire playback_switch_pkg::word_t pwdata, prdata,
    input wire logic pready, pslverr, line_sync_ref, chroma_ctrl_out, headamp_select_out
);
    import playback_switch_pkg::*;
    localparam logic [15:0] CTL_A = 16'(`SPC_CTRL_INDEX << 2);
    localparam logic [15:0] CFG_A = 16'(`SPC_PORT_CFG_INDEX << 2);
    logic [7:0] ctl_ff;
    logic       en_ff;
    logic [3:0] stab_ff, age_ff, f;
    wire        hit = psel && penable && pwrite && pready;
    assign f = ctl_ff[3:0];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // shadow of the control byte, switch enable, settle and sync age counters
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_ff <= 8'h00;
            en_ff <= 1'b0;
            stab_ff <= 4'h0;
            age_ff <= 4'h0;
        end else begin
            if (standby || module_stop) ctl_ff <= 8'h00;
            else if (hit && paddr == CTL_A) ctl_ff <= pwdata[7:0];
            if (hit && paddr == CFG_A) en_ff <= pwdata[0];
            if (hit || standby || module_stop) stab_ff <= 4'h0;
            else if (stab_ff != 4'hF) stab_ff <= stab_ff + 4'h1;
            if ($rose(line_sync_ref)) age_ff <= 4'h0;
            else if (age_ff != 4'hF) age_ff <= age_ff + 4'h1;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    a_ready_timing: assert property (s_setup ##1 (psel && penable) |=> pready) else $error("late ready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data not idle");
    a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
    a_ctl_wonly: assert property (pready && !pwrite && paddr == CTL_A |-> prdata == 32'h0)
        else $error("control byte readable");
    a_amp_const: assert property (en_ff && ctl_ff[4] && stab_ff == 4'hF && f <= 4'h2
        |-> headamp_select_out == (f == 4'h2)) else $error("headamp constant wrong");
    a_chroma_const: assert property (en_ff && ctl_ff[5] && stab_ff == 4'hF
        && (f == 4'h0 || f == 4'h3 || f == 4'h4) |-> chroma_ctrl_out == (f == 4'h4))
        else $error("chroma constant wrong");
    a_sync_hold: assert property (en_ff && !ctl_ff[4] && age_ff >= 4'h8 && stab_ff >= 4'h8
        |=> $stable(headamp_select_out)) else $error("headamp moved off sync edge");
endmodule // playback_switch_props
bind four_head_playback_switch playback_switch_props i_props (.*);

// file: tb/preamp_model.sv
// pre-amplifier stand-in that reports which head output is stronger
`timescale 1ns/1ps
module preamp_model (
    input wire logic ref_clk,
    input wire logic pick,
    output logic     compare_in
);
    // comparison result follows the stronger head one clock later
    always_ff @(posedge ref_clk) begin
        compare_in <= pick;
    end
endmodule // preamp_model

// file: tb/tb.sv
// self-checking bench for the four-head playback switch
`timescale 1ns/1ps
`include "playback_switch_params.svh"
module tb;
    import playback_switch_pkg::*;
    localparam logic [15:0] CTL_A = 16'(`SPC_CTRL_INDEX << 2);
    localparam logic [15:0] CFG_A = 16'(`SPC_PORT_CFG_INDEX << 2);
    localparam logic [15:0] STA_A = 16'(`SPC_STATUS_INDEX << 2);
    logic ref_clk = 0, rst_b = 0, standby = 0, module_stop = 0, psel = 0, penable = 0;
    logic pwrite = 0, vff = 0, nff = 0, lsr = 0, rtp = 0, pick = 0, pready, pslverr, er;
    logic cmp, cro, amo, cpi;
    logic [15:0] paddr = 16'h0000;
    word_t pwdata = 32'h0, prdata, rd;
    int err_total = 0, checked = 0;
    // control byte, video, narrow, compare, port bit, expected chroma and headamp
    logic [13:0] rows [12] = '{{8'h30,6'h3C}, {8'h31,6'h22}, {8'h32,6'h01}, {8'h33,6'h21},
        {8'h34,6'h02}, {8'h35,6'h22}, {8'h36,6'h20}, {8'h37,6'h07}, {8'h38,6'h05},
        {8'h3F,6'h20}, {8'hB1,6'h12}, {8'h75,6'h03}};
    always #12.5 ref_clk = ~ref_clk;
    preamp_model i_preamp_model (.ref_clk(ref_clk), .pick(pick), .compare_in(cmp));
    four_head_playback_switch i_four_head_playback_switch (.ref_clk(ref_clk), .rst_b(rst_b),
        .standby(standby), .module_stop(module_stop), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .video_ff_signal(vff), .narrow_ff_signal(nff),
        .line_sync_ref(lsr), .realtime_port_bit0(rtp), .compare_in(cmp),
        .chroma_ctrl_out(cro), .headamp_select_out(amo), .compare_port_in(cpi));
    task close_out;
        $display("mismatches %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (e !== s) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // one apb transfer, held until ready is sampled high
    task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task pulse;
        lsr <= 1;
        wt(3);
        lsr <= 0;
        wt(8);
    endtask
    initial begin
        wt(12);
        rst_b <= 1;
        wt(4);
        chk("reset outputs", 32'h0, {cro, amo});
        apb(1, CFG_A, 8'h06);
        wt(6);
        chk("port outputs", 32'h3, {cro, amo});
        apb(1, CFG_A, 8'h01);
        apb(0, CTL_A, 8'h00);
        chk("control read", 32'h0, rd);
        apb(0, 16'h0100, 8'h00);
        chk("unmapped error", 32'h1, er);
        // async rows through field codes 0 to 8 and F, both waveforms, both polarities
        foreach (rows[i]) begin
            apb(1, CTL_A, rows[i][13:6]);
            {vff, nff, pick, rtp} <= rows[i][5:2];
            wt(8);
            chk("row outputs", rows[i][1:0], {cro, amo});
        end
        pick <= 1;
        wt(6);
        chk("compare port", 32'h1, cpi);
        apb(0, STA_A, 8'h00);
        chk("status read", 32'h4, rd);
        apb(1, CTL_A, 8'h01);
        vff <= 1;
        pulse();
        chk("sync update", 32'h2, {cro, amo});
        vff <= 0;
        wt(10);
        chk("sync hold", 32'h1, cro);
        pulse();
        chk("sync edge", 32'h0, cro);
        apb(1, CTL_A, 8'h31);
        vff <= 1;
        wt(8);
        standby <= 1;
        wt(2);
        standby <= 0;
        pulse();
        chk("standby clear", 32'h0, cro);
        close_out();
    end
endmodule // tb
